/* File: swi_pkg.sv */
// Shared constants and types for the sensor serial register and threshold
// interrupt block.
// Assumes one sys_clk domain and one conversion-clock domain.
//
// Behaviour
// (R1) Answer only the ordered fixed 7-bit address
// (R2) Write word: address, command, low, high; ack each
// (R3) Read word: repeated start, low acked, high nacked
// (R4) Every command accessed as two-byte words only
// (R5) Device drives only acks and read data
// (R6) Light 16 bits; proximity 12 or 16 bits
// (R7) Reading flag register clears flags and interrupt
// (R8) Light interrupt only outside threshold window
// (R9) Proximity interrupt above high or below low
// (R10) Separate high and low flags per channel
// (R11) Proximity persistence counts consecutive crossings, else resets
// (R12) First proximity config: duty, time, enable, persistence; code has no integration time field
// (R13) Subtract crosstalk offset before compare and output
// (R14) Mode select: interrupt or proximity logic output
// (R15) Smart persistence re-measures fast after crossing
// (R16) Codes 0x01, 0x02 hold light thresholds
// (R17) Code 0x0D high byte holds channel flags, sunlight
// (R18) Interrupt active low, open drain, held until read
package swi_pkg;

    // ------------------------------------------------------------------
    // Addressing and command codes
    // ------------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h60;
    localparam logic [7:0] CMD_LIGHT_CFG = 8'h00;
    localparam logic [7:0] CMD_LIGHT_HIGH = 8'h01;
    localparam logic [7:0] CMD_LIGHT_LOW = 8'h02;
    localparam logic [7:0] CMD_PROX_CFG1 = 8'h03;
    localparam logic [7:0] CMD_PROX_CFG3 = 8'h04;
    localparam logic [7:0] CMD_PROX_OFFSET = 8'h05;
    localparam logic [7:0] CMD_PROX_LOW = 8'h06;
    localparam logic [7:0] CMD_PROX_HIGH = 8'h07;
    localparam logic [7:0] CMD_PROX_DATA = 8'h08;
    localparam logic [7:0] CMD_LIGHT_DATA = 8'h0B;
    localparam logic [7:0] CMD_FLAGS = 8'h0D;
    localparam logic [7:0] CMD_ID = 8'h0E;
    // Identity word: value is arbitrary
    localparam logic [15:0] ID_WORD = 16'h00A5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] LIGHT_CFG_RST = 16'h0101;
    localparam logic [15:0] PROX_CFG1_RST = 16'h0001;
    localparam logic [15:0] ZERO_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LIGHT_OFF_BIT = 0;
    localparam int LIGHT_INT_EN_BIT = 1;
    localparam int PROX_OFF_BIT = 0;
    localparam int PROX_PERS_LSB = 4;
    localparam int PROX_DUTY_LSB = 6;
    localparam int PROX_TRIG_LSB = 8;
    localparam int PROX_RES16_BIT = 11;
    localparam int PROX_SMART_BIT = 4;
    localparam int PROX_MODE_SEL_BIT = 14;
    // Flag bits inside the high byte of the flag word
    localparam int FLAG_PROX_AWAY = 8;
    localparam int FLAG_PROX_CLOSE = 9;
    localparam int FLAG_LIGHT_HIGH = 12;
    localparam int FLAG_LIGHT_LOW = 13;
    localparam int FLAG_SUN = 14;
    localparam logic [15:0] PROX_12BIT_MAX = 16'h0FFF;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 100;
    localparam int PROX_BASE_US = 40;
    localparam int PROX_FAST_US = 10;
    localparam logic [15:0] PROX_BASE_CYC = 16'(PROX_BASE_US * SYS_CLK_MHZ);
    localparam logic [15:0] PROX_FAST_CYC = 16'(PROX_FAST_US * SYS_CLK_MHZ);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_TXACK, I2C_IGNORE
    } swi_i2c_e;

    typedef struct packed {
        logic [15:0] lightCfg;
        logic [15:0] lightHigh;
        logic [15:0] lightLow;
        logic [15:0] proxCfg1;
        logic [15:0] proxCfg3;
        logic [15:0] proxOffset;
        logic [15:0] proxLow;
        logic [15:0] proxHigh;
    } swi_regs_s;

    typedef struct packed {
        logic valid;
        logic isProx;
        logic sun;
        logic [15:0] data;
    } swi_conv_s;

endpackage

/* File: swi_core.sv */
// Serial word-register slave, result processing and threshold interrupt.
// Assumes SCL/SDA arrive asynchronously and conversion results arrive on
// convClk, spaced far enough apart for a toggle crossing (>4 sys_clk).
`timescale 1ns/1ps
module swi_core (
    // Clocks and reset
    input wire logic sysClk,
    input wire logic rst,
    input wire logic convClk,
    // Two-wire bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Interrupt pin, open drain
    output logic intOut,
    output logic intOe,
    // Conversion front end
    input wire swi_pkg::swi_conv_s conv,
    output logic proxTrigTgl,
    output logic lightOn
);

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic tgl;
        logic isProx;
        logic sun;
        logic [15:0] data;
    } swi_cstate_s;

    typedef struct packed {
        swi_pkg::swi_i2c_e st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [2:0] byteIdx;
        logic readMode;
        logic [7:0] cmd;
        logic [7:0] wrLo;
        logic [15:0] txWord;
        logic txHi;
        logic sdaOe;
        swi_pkg::swi_regs_s regs;
        logic [15:0] proxData;
        logic [15:0] lightData;
        logic [15:0] flags;
        logic [2:0] persCnt;
        logic proxClose;
        logic [15:0] schedCnt;
        logic trigTgl;
        logic intOe;
        logic lightOn;
        logic [2:0] sclS;
        logic [2:0] sdaS;
        logic [2:0] tglS;
    } swi_state_s;

    swi_cstate_s c_q, c_d;
    swi_state_s s_q, s_d;

    // ------------------------------------------------------------------
    // Conversion domain: hold result and toggle to announce it
    // ------------------------------------------------------------------
    always_comb begin
        c_d = c_q;
        if (conv.valid) begin
            c_d.data = conv.data;
            c_d.isProx = conv.isProx;
            c_d.sun = conv.sun;
            c_d.tgl = ~c_q.tgl;
        end
    end

    always_ff @(posedge convClk or posedge rst) begin
        if (rst) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    function automatic logic [15:0] readReg(input swi_state_s s, input logic [7:0] code);
        logic [15:0] v;
        v = 16'h0000;
        case (code)
            swi_pkg::CMD_LIGHT_CFG: v = s.regs.lightCfg;
            swi_pkg::CMD_LIGHT_HIGH: v = s.regs.lightHigh; // R16
            swi_pkg::CMD_LIGHT_LOW: v = s.regs.lightLow; // R16
            swi_pkg::CMD_PROX_CFG1: v = s.regs.proxCfg1;
            swi_pkg::CMD_PROX_CFG3: v = s.regs.proxCfg3;
            swi_pkg::CMD_PROX_OFFSET: v = s.regs.proxOffset;
            swi_pkg::CMD_PROX_LOW: v = s.regs.proxLow;
            swi_pkg::CMD_PROX_HIGH: v = s.regs.proxHigh;
            swi_pkg::CMD_PROX_DATA: v = s.proxData; // R6
            swi_pkg::CMD_LIGHT_DATA: v = s.lightData; // R6
            swi_pkg::CMD_FLAGS: v = s.flags; // R17
            swi_pkg::CMD_ID: v = swi_pkg::ID_WORD;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // System domain: bus slave, result processing, interrupt
    // ------------------------------------------------------------------
    logic sclRise, sclFall, sdaNow, startCond, stopCond, newResult;
    logic [15:0] prox, setFlags;
    logic [2:0] need, cntNew;
    logic above, below, outside, fire, clearFlags, smartRun;
    logic [7:0] txByte;

    always_comb begin
        s_d = s_q;
        clearFlags = 1'b0;
        setFlags = 16'h0000;
        // Synchronisers; only stage 2 and 3 are looked at
        s_d.sclS = {s_q.sclS[1:0], sclIn};
        s_d.sdaS = {s_q.sdaS[1:0], sdaIn};
        s_d.tglS = {s_q.tglS[1:0], c_q.tgl};
        sdaNow = s_q.sdaS[1];
        sclRise = s_q.sclS[1] & ~s_q.sclS[2];
        sclFall = ~s_q.sclS[1] & s_q.sclS[2];
        startCond = s_q.sclS[1] & s_q.sclS[2] & ~s_q.sdaS[1] & s_q.sdaS[2];
        stopCond = s_q.sclS[1] & s_q.sclS[2] & s_q.sdaS[1] & ~s_q.sdaS[2];
        txByte = s_q.txHi ? s_q.txWord[15:8] : s_q.txWord[7:0]; // R3

        // Bus state machine; device drives SDA only for acks and read data
        if (startCond) begin
            s_d.st = swi_pkg::I2C_RX;
            s_d.bitCnt = 4'h0;
            s_d.byteIdx = 3'h0;
            s_d.txHi = 1'b0;
            s_d.sdaOe = 1'b0;
        end else if (stopCond) begin
            s_d.st = swi_pkg::I2C_IDLE; // R4
            s_d.sdaOe = 1'b0;
        end else begin
            case (s_q.st)
                swi_pkg::I2C_RX: begin
                    if (sclRise) begin
                        s_d.shift = {s_q.shift[6:0], sdaNow};
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end else if (sclFall && s_q.bitCnt == 4'h8) begin
                        s_d.bitCnt = 4'h0;
                        s_d.byteIdx = s_q.byteIdx + 3'h1;
                        s_d.st = swi_pkg::I2C_ACK;
                        s_d.sdaOe = 1'b1; // R2
                        case (s_q.byteIdx)
                            3'h0: begin
                                if (s_q.shift[7:1] == swi_pkg::SLAVE_ADDR) begin // R1
                                    s_d.readMode = s_q.shift[0];
                                    if (s_q.shift[0]) begin
                                        // Word latched once so both bytes pair
                                        s_d.txWord = readReg(s_q, s_q.cmd);
                                        clearFlags = (s_q.cmd == swi_pkg::CMD_FLAGS); // R7
                                    end
                                end else begin
                                    s_d.st = swi_pkg::I2C_IGNORE;
                                    s_d.sdaOe = 1'b0;
                                end
                            end
                            3'h1: s_d.cmd = s_q.shift;
                            3'h2: s_d.wrLo = s_q.shift;
                            3'h3: begin
                                // Commit only on the high byte: word access
                                case (s_q.cmd)
                                    swi_pkg::CMD_LIGHT_CFG: s_d.regs.lightCfg = {s_q.shift, s_q.wrLo};
                                    swi_pkg::CMD_LIGHT_HIGH: s_d.regs.lightHigh = {s_q.shift, s_q.wrLo}; // R16
                                    swi_pkg::CMD_LIGHT_LOW: s_d.regs.lightLow = {s_q.shift, s_q.wrLo}; // R16
                                    swi_pkg::CMD_PROX_CFG1: s_d.regs.proxCfg1 = {s_q.shift, s_q.wrLo}; // R12
                                    swi_pkg::CMD_PROX_CFG3: s_d.regs.proxCfg3 = {s_q.shift, s_q.wrLo};
                                    swi_pkg::CMD_PROX_OFFSET: s_d.regs.proxOffset = {s_q.shift, s_q.wrLo};
                                    swi_pkg::CMD_PROX_LOW: s_d.regs.proxLow = {s_q.shift, s_q.wrLo};
                                    swi_pkg::CMD_PROX_HIGH: s_d.regs.proxHigh = {s_q.shift, s_q.wrLo};
                                    default: s_d.cmd = s_q.cmd;
                                endcase
                            end
                            default: begin
                                // Extra bytes beyond a word are not acked
                                s_d.st = swi_pkg::I2C_IGNORE;
                                s_d.sdaOe = 1'b0;
                            end
                        endcase
                    end
                end
                swi_pkg::I2C_ACK: begin
                    if (sclFall) begin
                        if (s_q.readMode && s_q.byteIdx == 3'h1) begin
                            s_d.st = swi_pkg::I2C_TX;
                            s_d.sdaOe = ~txByte[7];
                            s_d.bitCnt = 4'h1;
                        end else if (s_q.byteIdx == 3'h4) begin
                            s_d.st = swi_pkg::I2C_IGNORE; // R2
                            s_d.sdaOe = 1'b0;
                        end else begin
                            s_d.st = swi_pkg::I2C_RX;
                            s_d.sdaOe = 1'b0;
                        end
                    end
                end
                swi_pkg::I2C_TX: begin
                    if (sclFall) begin
                        if (s_q.bitCnt == 4'h8) begin
                            s_d.sdaOe = 1'b0;
                            s_d.st = swi_pkg::I2C_TXACK;
                        end else begin
                            s_d.sdaOe = ~txByte[3'(4'h7 - s_q.bitCnt)]; // R5
                            s_d.bitCnt = s_q.bitCnt + 4'h1;
                        end
                    end
                end
                swi_pkg::I2C_TXACK: begin
                    if (sclRise) begin
                        if (!sdaNow && !s_q.txHi) begin
                            s_d.txHi = 1'b1; // R3
                            s_d.bitCnt = 4'h0;
                            s_d.st = swi_pkg::I2C_TX;
                        end else begin
                            s_d.st = swi_pkg::I2C_IGNORE;
                        end
                    end
                end
                swi_pkg::I2C_IDLE, swi_pkg::I2C_IGNORE: s_d.sdaOe = 1'b0;
                default: s_d.st = swi_pkg::I2C_IDLE;
            endcase
        end

        // Result processing: offset, resolution clamp, window compare
        newResult = s_q.tglS[1] ^ s_q.tglS[2];
        prox = (c_q.data > s_q.regs.proxOffset) ? 16'(c_q.data - s_q.regs.proxOffset) : 16'h0000; // R13
        if (!s_q.regs.proxCfg1[swi_pkg::PROX_RES16_BIT] && prox > swi_pkg::PROX_12BIT_MAX) begin
            prox = swi_pkg::PROX_12BIT_MAX; // R6
        end
        above = prox > s_q.regs.proxHigh; // R9
        below = prox < s_q.regs.proxLow; // R9
        outside = above | below;
        need = {1'b0, s_q.regs.proxCfg1[swi_pkg::PROX_PERS_LSB +: 2]} + 3'h1;
        cntNew = outside ? ((s_q.persCnt >= need) ? need : s_q.persCnt + 3'h1) : 3'h0; // R11
        fire = outside && cntNew >= need; // R11
        if (newResult) begin
            if (c_q.isProx) begin
                s_d.proxData = prox; // R13
                s_d.persCnt = cntNew;
                if (fire) begin
                    s_d.proxClose = above; // R14
                end
                setFlags[swi_pkg::FLAG_PROX_CLOSE] = fire & above & s_q.regs.proxCfg1[swi_pkg::PROX_TRIG_LSB]; // R10
                setFlags[swi_pkg::FLAG_PROX_AWAY] = fire & below & s_q.regs.proxCfg1[swi_pkg::PROX_TRIG_LSB + 1]; // R10
                setFlags[swi_pkg::FLAG_SUN] = c_q.sun; // R17
            end else if (!s_q.regs.lightCfg[swi_pkg::LIGHT_OFF_BIT]) begin
                s_d.lightData = c_q.data; // R6
                if (s_q.regs.lightCfg[swi_pkg::LIGHT_INT_EN_BIT]) begin
                    setFlags[swi_pkg::FLAG_LIGHT_HIGH] = c_q.data > s_q.regs.lightHigh; // R8
                    setFlags[swi_pkg::FLAG_LIGHT_LOW] = c_q.data < s_q.regs.lightLow; // R8
                end
            end
        end
        // A new event in the clearing cycle survives the clear
        s_d.flags = (clearFlags ? 16'h0000 : s_q.flags) | setFlags; // R7

        // Measurement scheduler: duty sets the interval, smart mode shortens it
        smartRun = s_q.regs.proxCfg3[swi_pkg::PROX_SMART_BIT] && s_q.persCnt != 3'h0 && s_q.persCnt < need; // R15
        if (s_q.regs.proxCfg1[swi_pkg::PROX_OFF_BIT]) begin
            s_d.schedCnt = 16'h0000;
        end else if (s_q.schedCnt == 16'h0000) begin
            s_d.trigTgl = ~s_q.trigTgl;
            s_d.schedCnt = smartRun ? swi_pkg::PROX_FAST_CYC
                : 16'(swi_pkg::PROX_BASE_CYC << s_q.regs.proxCfg1[swi_pkg::PROX_DUTY_LSB +: 2]); // R12 R15
        end else begin
            s_d.schedCnt = s_q.schedCnt - 16'h0001;
        end
        s_d.lightOn = ~s_q.regs.lightCfg[swi_pkg::LIGHT_OFF_BIT];

        // Interrupt pin pulled low while asserted
        if (s_q.regs.proxCfg3[swi_pkg::PROX_MODE_SEL_BIT]) begin
            s_d.intOe = s_d.proxClose; // R14
        end else begin
            s_d.intOe = |(s_d.flags & 16'h7300); // R18
        end
    end

    // Single register stage for all system-domain state
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= swi_pkg::I2C_IDLE;
            s_q.regs.lightCfg <= swi_pkg::LIGHT_CFG_RST;
            s_q.regs.proxCfg1 <= swi_pkg::PROX_CFG1_RST;
            s_q.regs.proxCfg3 <= swi_pkg::ZERO_RST;
            s_q.sclS <= 3'h7;
            s_q.sdaS <= 3'h7;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; pins only ever pull low
    assign sdaOut = 1'b0;
    assign intOut = 1'b0;
    assign sdaOe = s_q.sdaOe;
    assign intOe = s_q.intOe;
    assign proxTrigTgl = s_q.trigTgl;
    assign lightOn = s_q.lightOn;

endmodule

/* File: swi_host_model.sv */
// Host-side two-wire bus master model driving word transfers.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module swi_host_model #(
    parameter int QTR = 100
) (
    // Bus lines
    output logic scl,
    output logic sdaLow,
    input wire logic sdaLine
);
    // ----------------------------------------------------------------
    // Bus conditions and byte moves
    // ----------------------------------------------------------------
    // Idle released; a stuck-low line here would look like a start
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // Serves as first start and as repeated start
    task automatic startCond();
        sdaLow = 1'b0;
        #QTR scl = 1'b1;
        #QTR sdaLow = 1'b1;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic stopCond();
        sdaLow = 1'b1;
        #QTR scl = 1'b1;
        #QTR sdaLow = 1'b0;
        #(2 * QTR);
    endtask

    // Data changes only while the clock is low
    task automatic putByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaLow = ~b[i];
            #QTR scl = 1'b1;
            #(2 * QTR) scl = 1'b0;
            #QTR;
        end
        sdaLow = 1'b0;
        #QTR scl = 1'b1;
        #QTR ack = ~sdaLine;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic getByte(input logic ackIt, output logic [7:0] b);
        sdaLow = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #QTR scl = 1'b1;
            #QTR b[i] = sdaLine;
            #QTR scl = 1'b0;
            #QTR;
        end
        sdaLow = ackIt;
        #QTR scl = 1'b1;
        #(2 * QTR) scl = 1'b0;
        #QTR;
    endtask

    // Always two data bytes, low byte first
    task automatic wordWrite(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] data,
                             output logic [3:0] acks);
        startCond();
        putByte({addr, 1'b0}, acks[3]);
        putByte(cmd, acks[2]);
        putByte(data[7:0], acks[1]);
        putByte(data[15:8], acks[0]);
        stopCond();
    endtask

    task automatic wordRead(input logic [7:0] cmd, output logic [15:0] data, output logic [2:0] acks);
        startCond();
        putByte({swi_pkg::SLAVE_ADDR, 1'b0}, acks[2]);
        putByte(cmd, acks[1]);
        startCond();
        putByte({swi_pkg::SLAVE_ADDR, 1'b1}, acks[0]);
        getByte(1'b1, data[7:0]);
        getByte(1'b0, data[15:8]);
        stopCond();
    endtask
endmodule

/* File: swi_core_properties.sv */
// Pin-level checks on the word slave and interrupt output.
// Assumes rst is high from time zero; bound to swi_core below.
`timescale 1ns/1ps
module swi_core_chk (
    // Clocks and reset
    input wire logic sysClk,
    input wire logic rst,
    input wire logic convClk,
    // Bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Interrupt pin
    input wire logic intOut,
    input wire logic intOe,
    // Front end
    input wire swi_pkg::swi_conv_s conv,
    input wire logic proxTrigTgl,
    input wire logic lightOn
);
    default clocking cb @(posedge sysClk); endclocking
    default disable iff (rst);
    logic [7:0] sinceConv_q;
    logic [15:0] sinceTgl_q;
    logic tglSeen_q;

    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    // Saturating ages of the last result and last trigger toggle
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            sinceConv_q <= 8'hFF;
            sinceTgl_q <= 16'h0000;
            tglSeen_q <= 1'b0;
        end else begin
            tglSeen_q <= proxTrigTgl;
            sinceConv_q <= conv.valid ? 8'h00 : sinceConv_q + {7'h00, sinceConv_q != 8'hFF};
            sinceTgl_q <= (proxTrigTgl != tglSeen_q) ? 16'h0000 : sinceTgl_q + {15'h0000, sinceTgl_q != 16'hFFFF};
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sda_value_zero_a: assert property (sdaOut == 1'b0) else $error("data pin value not low");
    int_value_zero_a: assert property (intOut == 1'b0) else $error("interrupt pin value not low");
    sda_low_change_a: assert property ($changed(sdaOe) |-> !sclIn) else $error("data moved with clock high");
    sda_bit_hold_a: assert property ($rose(sdaOe) |-> sdaOe[*8]) else $error("driven bit too short");
    int_after_result_a: assert property ($rose(intOe) |-> sinceConv_q <= 8'h10)
        else $error("interrupt without a fresh result");
    int_clear_read_a: assert property ($fell(intOe) |-> ##[0:3] sdaOe)
        else $error("interrupt dropped outside a read");
    trig_spacing_a: assert property (proxTrigTgl != tglSeen_q |-> sinceTgl_q >= 16'h03DE)
        else $error("measurement requests too close");
    cfg_on_write_a: assert property ($changed(lightOn) |-> ##[0:2] sdaOe)
        else $error("light enable moved outside a write");

    // Main scenarios reached
    cover property ($rose(intOe));
    cover property ($fell(intOe));
    cover property (proxTrigTgl != tglSeen_q);
endmodule

bind swi_core swi_core_chk i_chk (
    .sysClk(sysClk), .rst(rst), .convClk(convClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe), .conv(conv), .proxTrigTgl(proxTrigTgl), .lightOn(lightOn)
);

/* File: tb_sensor_word_i2c_and_threshold_irq.sv */
// Self-checking bench: host word transfers, results and interrupt pin.
// Assumes swi_pkg, swi_core, the host model and the checker compile first.
`timescale 1ns/1ps
module tb_sensor_word_i2c_and_threshold_irq;
    logic sysClk, convClk, rst, sdaOut, sdaOe, intOut, intOe, proxTrigTgl, lightOn, scl, hostLow;
    swi_pkg::swi_conv_s conv;
    int fail_count;
    int n_checks;
    // Pull-up: line low while any party pulls it
    wire sdaLine = ~(hostLow | sdaOe);

    // Free-running clocks, unrelated in phase
    initial begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end
    initial begin
        convClk = 1'b0;
        #3;
        forever #40 convClk = ~convClk;
    end

    swi_core i_dut (
        .sysClk(sysClk), .rst(rst), .convClk(convClk), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe), .conv(conv), .proxTrigTgl(proxTrigTgl), .lightOn(lightOn)
    );
    swi_host_model i_host (.scl(scl), .sdaLow(hostLow), .sdaLine(sdaLine));

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        logic [3:0] acks;
        i_host.wordWrite(swi_pkg::SLAVE_ADDR, cmd, data, acks);
        check({12'h0, acks}, 16'h000F);
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] data;
        logic [2:0] acks;
        i_host.wordRead(cmd, data, acks);
        check({13'h0, acks}, 16'h0007);
        check(data, exp);
    endtask

    // One result pulse, then time for it to be processed
    task automatic result(input logic isProx, input logic [15:0] data);
        @(posedge convClk);
        conv <= '{valid: 1'b1, isProx: isProx, sun: 1'b0, data: data};
        @(posedge convClk);
        conv.valid <= 1'b0;
        repeat (20) @(negedge sysClk);
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [3:0] acks;
        logic tglStart;
        int waited;
        rst = 1'b1;
        conv = '0;
        fail_count = 0;
        n_checks = 0;
        repeat (12) @(posedge sysClk);
        rst <= 1'b0;
        repeat (8) @(negedge sysClk);
        rd(swi_pkg::CMD_LIGHT_CFG, swi_pkg::LIGHT_CFG_RST);
        rd(swi_pkg::CMD_PROX_CFG1, swi_pkg::PROX_CFG1_RST);
        rd(swi_pkg::CMD_ID, swi_pkg::ID_WORD);
        wr(swi_pkg::CMD_LIGHT_HIGH, 16'h1234);
        wr(swi_pkg::CMD_LIGHT_LOW, 16'h0100);
        rd(swi_pkg::CMD_LIGHT_HIGH, 16'h1234);
        rd(swi_pkg::CMD_LIGHT_LOW, 16'h0100);
        // Another part's address gets no answer and stores nothing
        i_host.wordWrite(7'h51, swi_pkg::CMD_LIGHT_HIGH, 16'hBEEF, acks);
        check({12'h0, acks}, 16'h0000);
        rd(swi_pkg::CMD_LIGHT_HIGH, 16'h1234);
        wr(swi_pkg::CMD_LIGHT_DATA, 16'h5555);
        rd(swi_pkg::CMD_LIGHT_DATA, 16'h0000);
        rd(8'h09, 16'h0000);
        // Light window: inside, above, then below
        wr(swi_pkg::CMD_LIGHT_CFG, 16'h0002);
        check({15'h0, lightOn}, 16'h0001);
        result(1'b0, 16'h0200);
        check({15'h0, intOe}, 16'h0000);
        result(1'b0, 16'h2000);
        check({15'h0, intOe}, 16'h0001);
        rd(swi_pkg::CMD_FLAGS, 16'h1000);
        check({15'h0, intOe}, 16'h0000);
        rd(swi_pkg::CMD_FLAGS, 16'h0000);
        result(1'b0, 16'h0050);
        rd(swi_pkg::CMD_FLAGS, 16'h2000);
        rd(swi_pkg::CMD_LIGHT_DATA, 16'h0050);
        // Proximity with offset, persistence of three
        wr(swi_pkg::CMD_PROX_OFFSET, 16'h0010);
        wr(swi_pkg::CMD_PROX_HIGH, 16'h0100);
        wr(swi_pkg::CMD_PROX_LOW, 16'h0020);
        wr(swi_pkg::CMD_PROX_CFG1, 16'h0120);
        tglStart = proxTrigTgl;
        waited = 0;
        while (proxTrigTgl === tglStart && waited < 4100) begin
            @(negedge sysClk);
            waited++;
        end
        check({15'h0, proxTrigTgl}, {15'h0, ~tglStart});
        if (proxTrigTgl !== tglStart) begin
            // Third entry lands inside only once the offset is taken off
            for (int i = 0; i < 6; i++) begin
                result(1'b1, (i == 2) ? 16'h0108 : 16'h0200);
                check({15'h0, intOe}, {15'h0, i == 5});
            end
            rd(swi_pkg::CMD_PROX_DATA, 16'h01F0);
            rd(swi_pkg::CMD_FLAGS, 16'h0200);
            check({15'h0, intOe}, 16'h0000);
            // Logic mode: pin follows close state
            result(1'b1, 16'h0010);
            wr(swi_pkg::CMD_PROX_CFG3, 16'h4000);
            result(1'b0, 16'h2000);
            check({15'h0, intOe}, 16'h0000);
            result(1'b1, 16'h0200);
            check({15'h0, intOe}, 16'h0001);
        end
        print_verdict();
    end
endmodule
